// >>> verilog/jcmr_consts.svh
`ifndef JCMR_CONSTS_SVH
`define JCMR_CONSTS_SVH

// Avalon-MM register word offsets (byte addresses).
`define JCMR_OFS_CTRL 8'h00
`define JCMR_OFS_STATUS 8'h04
`define JCMR_OFS_ID 8'h08

// Control register fields.
`define JCMR_CTRL_USB_REQ_BIT 0
`define JCMR_CTRL_USB_TRST_BIT 1
`define JCMR_CTRL_USB_SRST_BIT 2
`define JCMR_CTRL_RESET 32'h0000_0000

// Status register fields.
`define JCMR_STAT_CFG_MODE_BIT 0
`define JCMR_STAT_PROBE_BIT 1
`define JCMR_STAT_USB_OWNS_BIT 2
`define JCMR_STAT_LOCKED_BIT 3
`define JCMR_STAT_RETURN_TEST_CLOCK_EN_BIT 4

// Cycles after reset release before the mode strap is captured.
`define JCMR_STRAP_SETTLE_CYC 8'h10

`endif

// >>> verilog/jcmr_pkg.sv
`default_nettype none
package jcmr_pkg;
    typedef enum logic {
        JCMR_MODE_DEBUG,
        JCMR_MODE_CONFIG
    } jcmr_mode_e;
    typedef enum logic [1:0] {
        JCMR_MASTER_NONE,
        JCMR_MASTER_PROBE,
        JCMR_MASTER_USB
    } jcmr_master_e;
endpackage
`default_nettype wire

// >>> verilog/jcmr_sync2.sv
`default_nettype none
module jcmr_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] rst_val_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [1:0] rst_val_r;

    if (WIDTH < 1) begin : g_bad_width
        $error("jcmr_sync2: WIDTH must be at least 1");
    end

    // Reset values are constants; the per-bit idle level stands in until both stages
    // hold real samples, so no false edge or strap level follows reset.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_val_r <= 2'h3;
        end else begin
            rst_val_r <= {rst_val_r[0], 1'b0};
        end
    end

    // Until the pipeline holds real samples, present the idle level of each line.
    always_comb begin
        sync_o = sync_r;
        if (rst_val_r != 2'h0) begin
            sync_o = rst_val_i;
        end
    end
endmodule // jcmr_sync2
`default_nettype wire

// >>> verilog/jcmr_edge_det.sv
`default_nettype none
module jcmr_edge_det (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic level_i,
    output logic rise_o,
    output logic fall_o
);
    logic prev_r;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_r;
    assign fall_o = ~level_i & prev_r;
endmodule // jcmr_edge_det
`default_nettype wire

// >>> verilog/jcmr_router.sv
// Contract
// - USB master yields when probe detected low
// - External tool disables embedded debug hardware
// - No jumper: debug mode, select high
// - Debug mode: config LEDs off everywhere
// - Debug mode: chain through CPU TAP, tiles
// - Debug mode: PLDs excluded unless debuggable
// - Debug mode: FPGAs load from flash
// - Jumper fitted: config mode, select low
// - Switch ON is config, OFF no jumper
// - Config mode: config LEDs lit everywhere
// - Config mode: scan over config chain
// - Config mode: all FPGAs, PLDs inserted
// - Config mode: boundary-scan TAP replaces CPU
// - Config mode: FPGA image chain or flash
// - Flash programmed through loader design
// - Data serial from TDI, returns TDO
// - Test clock fanned to all components
// - Return clock low or looped back
// - Config mode: resets drive FPGA init/program
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`include "jcmr_consts.svh"
`default_nettype none
module jcmr_router (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Avalon-MM slave.
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    // Straps and detect lines.
    input wire logic config_jumper_n_i,
    input wire logic external_probe_detect_n_i,
    input wire logic return_clock_enable_n_i,
    // External probe scan lines.
    input wire logic probe_tck_i,
    input wire logic probe_tms_i,
    input wire logic probe_tdi_i,
    input wire logic probe_trst_n_i,
    output logic probe_tdo_o,
    output logic return_test_clock_o,
    // Embedded USB debug master scan lines.
    input wire logic usb_tck_i,
    input wire logic usb_tms_i,
    input wire logic usb_tdi_i,
    output logic usb_tdo_o,
    // Open-drain system reset line.
    input wire logic system_reset_line_n_i,
    output logic system_reset_line_n_o,
    output logic system_reset_line_n_oe_o,
    // Shared chain fan-out.
    output logic chain_tck_o,
    output logic chain_tms_o,
    output logic chain_trst_n_o,
    // Debug chain.
    output logic dbg_tdi_o,
    input wire logic dbg_tdo_i,
    // Configuration chain.
    output logic cfg_tdi_o,
    input wire logic cfg_tdo_i,
    // Board controls.
    output logic config_mode_select_n_o,
    output logic config_led_o,
    output logic cpu_tap_enable_o,
    output logic bscan_tap_enable_o,
    output logic pld_in_chain_o,
    output logic fpga_flash_boot_o,
    output logic fpga_init_n_o,
    output logic fpga_program_n_o,
    output logic usb_master_enable_o
);
    localparam logic [7:0] STRAP_SETTLE = `JCMR_STRAP_SETTLE_CYC;
    localparam logic [31:0] ID_VALUE = 32'h0000_1A5E; // Arbitrary identification value.

    logic [6:0] async_vec;
    logic [6:0] idle_vec;
    logic [6:0] sync_vec;
    logic jumper_n_s, probe_det_n_s, rtcken_n_s, tck_s, tms_s, tdi_s, trst_n_s;

    // Pin levels cross into clk_sys_i before any decision is made on them.
    assign async_vec = {config_jumper_n_i, external_probe_detect_n_i, return_clock_enable_n_i,
                        probe_tck_i, probe_tms_i, probe_tdi_i, probe_trst_n_i};
    // Idle levels: straps and detect lines high, test clock low, mode select high.
    assign idle_vec = 7'h77;
    jcmr_sync2 #(.WIDTH(7)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .async_i(async_vec),
        .rst_val_i(idle_vec),
        .sync_o(sync_vec)
    );
    assign {jumper_n_s, probe_det_n_s, rtcken_n_s, tck_s, tms_s, tdi_s, trst_n_s} = sync_vec;

    logic tck_rise, tck_fall;
    jcmr_edge_det u_tck_edge (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .level_i(tck_s),
        .rise_o(tck_rise),
        .fall_o(tck_fall)
    );

    // Mode strap capture: one shot after reset settles, then frozen.
    logic [7:0] settle_cnt_r;
    logic locked_r;
    jcmr_pkg::jcmr_mode_e mode_r;
    logic cfg_mode;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            settle_cnt_r <= 8'h00;
            locked_r <= 1'b0;
        end else if (!locked_r) begin
            if (settle_cnt_r == STRAP_SETTLE) begin
                locked_r <= 1'b1;
            end else begin
                settle_cnt_r <= settle_cnt_r + 8'h01;
            end
        end
    end

    // Only a reset, which stands in for the power cycle, can change the mode later.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_r <= jcmr_pkg::JCMR_MODE_DEBUG;
        end else if (!locked_r && settle_cnt_r == STRAP_SETTLE) begin
            // A fitted jumper or switch ON pulls low; absent or OFF floats high.
            mode_r <= jumper_n_s ? jcmr_pkg::JCMR_MODE_DEBUG
                                 : jcmr_pkg::JCMR_MODE_CONFIG;
        end
    end
    assign cfg_mode = (mode_r == jcmr_pkg::JCMR_MODE_CONFIG);

    assign config_mode_select_n_o = ~cfg_mode;
    assign config_led_o = cfg_mode;
    assign cpu_tap_enable_o = ~cfg_mode;
    assign bscan_tap_enable_o = cfg_mode;
    assign pld_in_chain_o = cfg_mode;
    assign fpga_flash_boot_o = ~cfg_mode;

    // Master arbitration.
    logic [31:0] ctrl_r;
    logic usb_req, usb_owns;
    jcmr_pkg::jcmr_master_e master;
    assign usb_req = ctrl_r[`JCMR_CTRL_USB_REQ_BIT];
    assign usb_owns = usb_req & probe_det_n_s;
    assign usb_master_enable_o = usb_owns;

    always_comb begin
        if (!probe_det_n_s) begin
            master = jcmr_pkg::JCMR_MASTER_PROBE;
        end else if (usb_req) begin
            master = jcmr_pkg::JCMR_MASTER_USB;
        end else begin
            master = jcmr_pkg::JCMR_MASTER_PROBE;
        end
    end

    // The USB master is on-board logic in this clock domain, so it is not resynchronised.
    logic sel_tck, sel_tms, sel_tdi, sel_trst_n;
    always_comb begin
        unique case (master)
            jcmr_pkg::JCMR_MASTER_USB: begin
                sel_tck = usb_tck_i;
                sel_tms = usb_tms_i;
                sel_tdi = usb_tdi_i;
                sel_trst_n = ~ctrl_r[`JCMR_CTRL_USB_TRST_BIT];
            end
            default: begin
                sel_tck = tck_s;
                sel_tms = tms_s;
                sel_tdi = tdi_s;
                sel_trst_n = trst_n_s;
            end
        endcase
    end

    // Chain drive is registered; one cycle of skew is small against the slow test clock.
    logic tck_r, tms_r, tdi_r, trst_n_r, tdo_r;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tck_r <= 1'b0;
            tms_r <= 1'b1;
            tdi_r <= 1'b1;
            trst_n_r <= 1'b0;
        end else begin
            tck_r <= sel_tck;
            tms_r <= sel_tms;
            tdi_r <= sel_tdi;
            trst_n_r <= sel_trst_n;
        end
    end

    // The chain shifts out on the same edge that drops chain_tck_o, so returned data
    // is taken one cycle later, once the new bit stands on the return line.
    logic tck_fall_d_r;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tck_fall_d_r <= 1'b0;
        end else begin
            tck_fall_d_r <= tck_fall;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tdo_r <= 1'b1;
        end else if (usb_owns || tck_fall_d_r) begin
            tdo_r <= cfg_mode ? cfg_tdo_i : dbg_tdo_i;
        end
    end

    logic return_test_clock_r;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            return_test_clock_r <= 1'b0;
        end else if (rtcken_n_s) begin
            return_test_clock_r <= 1'b0;
        end else if (tck_rise) begin
            return_test_clock_r <= 1'b1;
        end else if (tck_fall) begin
            return_test_clock_r <= 1'b0;
        end
    end

    assign chain_tck_o = tck_r;
    assign chain_tms_o = tms_r;
    assign chain_trst_n_o = trst_n_r;
    assign dbg_tdi_o = cfg_mode ? 1'b1 : tdi_r;
    assign cfg_tdi_o = cfg_mode ? tdi_r : 1'b1;
    assign probe_tdo_o = tdo_r;
    assign usb_tdo_o = tdo_r;
    assign return_test_clock_o = return_test_clock_r;

    // The open-drain line is only ever pulled low, never driven high.
    logic srst_drive;
    assign srst_drive = usb_owns & ctrl_r[`JCMR_CTRL_USB_SRST_BIT];
    assign system_reset_line_n_o = 1'b0;
    assign system_reset_line_n_oe_o = srst_drive;

    logic srst_meta_r, srst_s_r;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            srst_meta_r <= 1'b1;
            srst_s_r <= 1'b1;
        end else begin
            srst_meta_r <= system_reset_line_n_i;
            srst_s_r <= srst_meta_r;
        end
    end

    // Outside configuration mode the FPGA control pins idle high.
    logic init_n_r, prog_n_r;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            init_n_r <= 1'b1;
            prog_n_r <= 1'b1;
        end else begin
            init_n_r <= cfg_mode ? srst_s_r : 1'b1;
            prog_n_r <= cfg_mode ? trst_n_r : 1'b1;
        end
    end
    assign fpga_init_n_o = init_n_r;
    assign fpga_program_n_o = prog_n_r;

    // Avalon-MM slave: one wait cycle, then answer.
    logic ack_r;
    logic [31:0] rdata_r;
    logic [1:0] resp_r;
    logic req, hit;
    assign req = avs_read_i | avs_write_i;
    assign hit = (avs_address_i == `JCMR_OFS_CTRL) || (avs_address_i == `JCMR_OFS_STATUS)
                 || (avs_address_i == `JCMR_OFS_ID);
    assign avs_waitrequest_o = req & ~ack_r;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= `JCMR_CTRL_RESET;
        end else if (avs_write_i && ack_r && avs_address_i == `JCMR_OFS_CTRL) begin
            // The write lands on the edge that completes the transfer.
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable_i[b]) begin
                    ctrl_r[b*8 +: 8] <= avs_writedata_i[b*8 +: 8] & 8'h07 & {8{b == 0}};
                end
            end
        end
    end

    logic [31:0] status;
    always_comb begin
        status = 32'h0000_0000;
        status[`JCMR_STAT_CFG_MODE_BIT] = cfg_mode;
        status[`JCMR_STAT_PROBE_BIT] = ~probe_det_n_s;
        status[`JCMR_STAT_USB_OWNS_BIT] = usb_owns;
        status[`JCMR_STAT_LOCKED_BIT] = locked_r;
        status[`JCMR_STAT_RETURN_TEST_CLOCK_EN_BIT] = ~rtcken_n_s;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 32'h0000_0000;
            resp_r <= 2'h0;
        end else if (req && !ack_r) begin
            resp_r <= hit ? 2'h0 : 2'h2;
            unique case (avs_address_i)
                `JCMR_OFS_CTRL: rdata_r <= avs_read_i ? ctrl_r : 32'h0000_0000;
                `JCMR_OFS_STATUS: rdata_r <= avs_read_i ? status : 32'h0000_0000;
                `JCMR_OFS_ID: rdata_r <= avs_read_i ? ID_VALUE : 32'h0000_0000;
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata_o = rdata_r;
    assign avs_response_o = resp_r;
endmodule // jcmr_router
`default_nettype wire

// >>> tb/jcmr_router_sva.sv
`default_nettype none
module jcmr_router_sva (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic external_probe_detect_n_i,
    input wire logic return_clock_enable_n_i,
    input wire logic system_reset_line_n_i,
    input wire logic cfg_tdi_o,
    input wire logic return_test_clock_o,
    input wire logic config_mode_select_n_o,
    input wire logic config_led_o,
    input wire logic cpu_tap_enable_o,
    input wire logic bscan_tap_enable_o,
    input wire logic pld_in_chain_o,
    input wire logic fpga_flash_boot_o,
    input wire logic fpga_init_n_o,
    input wire logic usb_master_enable_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic dm;
    assign dm = config_mode_select_n_o;
    a_led_mode:
    assert property (config_led_o == !dm) else $error("led disagrees with mode");
    a_cpu_tap_mode:
    assert property (cpu_tap_enable_o == dm) else $error("cpu tap disagrees with mode");
    a_cfg_devices_in:
    assert property (!dm |-> bscan_tap_enable_o && pld_in_chain_o)
        else $error("config devices missing");
    a_flash_boot_mode:
    assert property (fpga_flash_boot_o == dm) else $error("flash boot disagrees with mode");
    a_probe_wins_usb:
    assert property (!external_probe_detect_n_i [*4] |-> !usb_master_enable_o)
        else $error("usb master kept chain with probe present");
    a_mode_held_low:
    assert property (!dm |=> !dm) else $error("mode left config without reset");
    a_return_test_clock_held_low:
    assert property (return_clock_enable_n_i [*4] |-> !return_test_clock_o)
        else $error("return clock not low");
    a_cfg_chain_idle:
    assert property (dm [*2] |-> cfg_tdi_o) else $error("config chain not idle");
    a_init_follows:
    assert property ((!dm && !system_reset_line_n_i) [*4] |-> !fpga_init_n_o)
        else $error("init not driven by system reset");
    c_cfg_mode: cover property (!dm);
    c_usb_owner: cover property (usb_master_enable_o);
    c_return_test_clock_loop: cover property (return_test_clock_o);
endmodule // jcmr_router_sva
bind jcmr_router jcmr_router_sva jcmr_router_sva_inst (.*);
`default_nettype wire

// >>> tb/jcmr_probe_model.sv
`default_nettype none
module jcmr_probe_model (
    input wire logic probe_tdo_i,
    input wire logic chain_tck_i,
    input wire logic dbg_tdi_i,
    input wire logic cfg_tdi_i,
    output logic probe_tck_o,
    output logic probe_tms_o,
    output logic probe_tdi_o,
    output logic dbg_tdo_o,
    output logic cfg_tdo_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic dbg_r = 1'b0;
    logic cfg_r = 1'b0;
    initial begin
        probe_tck_o = 1'b0;
        probe_tms_o = 1'b1;
        probe_tdi_o = 1'b0;
        dbg_tdo_o = 1'b0;
        cfg_tdo_o = 1'b0;
    end
    // One-bit stages; the config stage inverts so a misrouted path shows.
    always @(posedge chain_tck_i) begin
        dbg_r <= dbg_tdi_i;
        cfg_r <= cfg_tdi_i;
    end
    always @(negedge chain_tck_i) begin
        dbg_tdo_o <= dbg_r;
        cfg_tdo_o <= ~cfg_r;
    end
    // The offset keeps the test clock off the system clock edges.
    task automatic shift(input logic tms, input logic tdi, output logic tdo);
        #1.5;
        probe_tms_o = tms;
        probe_tdi_o = tdi;
        #40 probe_tck_o = 1'b1;
        #40 probe_tck_o = 1'b0;
        #40 tdo = probe_tdo_i;
        probe_tdi_o = ~tdi;
    endtask
endmodule // jcmr_probe_model
`default_nettype wire

// >>> tb/jcmr_router_tb_top.sv
`default_nettype none
module jcmr_router_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic config_jumper_n_i = 1'b1, external_probe_detect_n_i = 1'b1;
    logic return_clock_enable_n_i = 1'b1, probe_trst_n_i = 1'b1;
    logic usb_tck_i = 1'b0, usb_tms_i = 1'b1, usb_tdi_i = 1'b0;
    logic probe_tck_i, probe_tms_i, probe_tdi_i, dbg_tdo_i, cfg_tdo_i, system_reset_line_n_i;
    logic [31:0] avs_readdata_o;
    logic [1:0] avs_response_o;
    logic avs_waitrequest_o, probe_tdo_o, return_test_clock_o, usb_tdo_o, system_reset_line_n_o;
    logic system_reset_line_n_oe_o, chain_tck_o, chain_tms_o, chain_trst_n_o, dbg_tdi_o;
    logic cfg_tdi_o, config_mode_select_n_o, config_led_o, cpu_tap_enable_o;
    logic bscan_tap_enable_o, pld_in_chain_o, fpga_flash_boot_o, fpga_init_n_o;
    logic fpga_program_n_o, usb_master_enable_o, b;
    int fails = 0, num_checks = 0, cyc = 0;
    logic [33:0] exp_q[$];
    assign system_reset_line_n_i = system_reset_line_n_oe_o ? system_reset_line_n_o : 1'b1;
    jcmr_router jcmr_router_inst (.*);
    jcmr_probe_model probe_model_inst (.probe_tdo_i(probe_tdo_o), .chain_tck_i(chain_tck_o),
        .dbg_tdi_i(dbg_tdi_o), .cfg_tdi_i(cfg_tdi_o), .probe_tck_o(probe_tck_i),
        .probe_tms_o(probe_tms_i), .probe_tdi_o(probe_tdi_i), .dbg_tdo_o(dbg_tdo_i),
        .cfg_tdo_o(cfg_tdo_i));
    initial forever #2 clk_sys_i = ~clk_sys_i;
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_bus(input logic [33:0] e, input logic [33:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR readback expected %h seen %h", e, g);
        end
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
        if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            chk_bus(exp_q.pop_front(), {avs_response_o, avs_readdata_o});
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [33:0] e);
        @(posedge clk_sys_i);
        if (!w) begin
            exp_q.push_back(e);
        end
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        @(posedge clk_sys_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    // The strap is taken 17 edges after release, so 20 leaves margin.
    task automatic do_reset(input logic j);
        rst_b_i <= 1'b0;
        config_jumper_n_i <= j;
        repeat (4) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
    endtask
    task automatic chk_mode(input logic c);
        chk_bit("select_n", !c, config_mode_select_n_o);
        chk_bit("led", c, config_led_o);
        chk_bit("cpu_tap", !c, cpu_tap_enable_o);
        chk_bit("bscan_tap", c, bscan_tap_enable_o);
        chk_bit("pld", c, pld_in_chain_o);
        chk_bit("flash_boot", !c, fpga_flash_boot_o);
    endtask
    task automatic scan(input logic c);
        logic t;
        for (int i = 0; i < 6; i++) begin
            b = 1'($urandom);
            probe_model_inst.shift(1'b0, b, t);
            chk_bit("tdo", c ? !b : b, t);
            chk_bit("usb_tdo", c ? !b : b, usb_tdo_o);
        end
        chk_bit("idle_tdi", 1'b1, c ? dbg_tdi_o : cfg_tdi_o);
    endtask
    initial begin
        void'($urandom(80388));
        do_reset(1'b1);
        chk_mode(1'b0);
        chk_bit("init_n", 1'b1, fpga_init_n_o);
        bus(1'b0, 8'h08, 32'h0, {2'b00, 32'h0000_1A5E});
        bus(1'b0, 8'h0C, 32'h0, {2'b10, 32'h0000_0000});
        external_probe_detect_n_i <= 1'b0;
        scan(1'b0);
        for (int k = 1; k >= 0; k--) begin
            @(posedge clk_sys_i);
            return_clock_enable_n_i <= k[0];
            fork
                probe_model_inst.shift(1'b1, 1'b1, b);
            join_none
            @(posedge probe_tck_i);
            repeat (8) @(posedge clk_sys_i);
            chk_bit("return_test_clock", !k[0], return_test_clock_o);
            wait fork;
        end
        @(posedge clk_sys_i);
        external_probe_detect_n_i <= 1'b1;
        bus(1'b1, 8'h00, 32'h0000_0001, 34'h0);
        bus(1'b0, 8'h04, 32'h0, {2'b00, 32'h0000_001C});
        for (int i = 0; i < 6; i++) begin
            usb_tdi_i <= 1'($urandom);
            usb_tck_i <= 1'($urandom);
            usb_tms_i <= 1'($urandom);
            repeat (4) @(posedge clk_sys_i);
            chk_bit("usb_tdi", usb_tdi_i, dbg_tdi_o);
            chk_bit("usb_tms", usb_tms_i, chain_tms_o);
            chk_bit("usb_tck", usb_tck_i, chain_tck_o);
        end
        external_probe_detect_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk_bit("usb_en", 1'b0, usb_master_enable_o);
        bus(1'b0, 8'h04, 32'h0, {2'b00, 32'h0000_001A});
        do_reset(1'b0);
        chk_mode(1'b1);
        scan(1'b1);
        @(posedge clk_sys_i);
        probe_trst_n_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk_bit("prog_n", 1'b0, fpga_program_n_o);
        chk_bit("chain_trst_n", 1'b0, chain_trst_n_o);
        probe_trst_n_i <= 1'b1;
        external_probe_detect_n_i <= 1'b1;
        bus(1'b1, 8'h00, 32'h0000_0005, 34'h0);
        repeat (6) @(posedge clk_sys_i);
        chk_bit("init_n", 1'b0, fpga_init_n_o);
        config_jumper_n_i <= 1'b1;
        repeat (30) @(posedge clk_sys_i);
        chk_mode(1'b1);
        bus(1'b0, 8'h04, 32'h0, {2'b00, 32'h0000_001D});
        repeat (2) @(posedge clk_sys_i);
        close_out();
    end
endmodule // jcmr_router_tb_top
`default_nettype wire
